// ==== include/eq_meter_pkg.sv ====
// Purpose: shared constants for the equalizer mode and meter register bank
// Assumes: register index times four gives the AXI4-Lite byte address
// Notes:   reset values of the mode registers are all zero
package eq_meter_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W  = 8;

  // register indices, byte address is index * 4
  localparam logic [ADDR_W-3:0] IDX_EQ_MODE    = 10'h03d;
  localparam logic [ADDR_W-3:0] IDX_PRED_MODE  = 10'h03e;
  localparam logic [ADDR_W-3:0] IDX_PHASE_LOW  = 10'h040;
  localparam logic [ADDR_W-3:0] IDX_PHASE_HIGH = 10'h041;
  localparam logic [ADDR_W-3:0] IDX_OVF_COUNT  = 10'h042;

  // equalizer_mode_control fields
  localparam int EQ_GAIN_BIT      = 0;
  localparam int EQ_ADAPT_BIT     = 1;
  localparam int EQ_ZERO_BIT      = 2;
  localparam int EQ_LAST_ONLY_BIT = 3;
  // predictor_mode_control fields
  localparam int PRED_GAIN_BIT     = 0;
  localparam int PRED_ADAPT_BIT    = 1;
  localparam int PRED_ZERO_BIT     = 2;
  localparam int PRED_ZERO_OUT_BIT = 3;
  localparam int MODE_W            = 4;

  localparam logic [MODE_W-1:0] EQ_MODE_RESET   = 4'h0;
  localparam logic [MODE_W-1:0] PRED_MODE_RESET = 4'h0;

  // step of four is a left shift by two
  localparam logic [1:0] EQ_STEP_SHIFT_HIGH = 2'h2;
  localparam logic [1:0] EQ_STEP_SHIFT_LOW  = 2'h0;

  // meters
  localparam int PHASE_ACC_W    = 26;
  localparam int PHASE_LOW_LSB  = 10;
  localparam int PHASE_HIGH_LSB = 18;
  localparam int OVF_ACC_W      = 8;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } wr_state_t;
endpackage

// ==== src/interval_meter.sv ====
// Purpose: accumulator that sums or counts over one meter interval and latches the result
// Assumes: inputs come from logic on i_clk
// Notes:   restarts from zero after every latch
`timescale 1ns/10ps
module interval_meter #(
  parameter int ACC_W    = 26,
  parameter int IN_W     = 12,
  parameter bit SIGNED   = 1'b1,
  parameter bit SATURATE = 1'b0
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic             i_interval_end,
  input  wire logic             i_valid,
  input  wire logic [IN_W-1:0]  i_sample,
  output logic      [ACC_W-1:0] o_result
);
  logic [ACC_W-1:0] acc;
  logic [ACC_W-1:0] next_acc;
  logic [ACC_W-1:0] next_result;
  logic [ACC_W-1:0] ext;
  logic [ACC_W-1:0] sum;

  always_comb
  begin
    ext = {{(ACC_W-IN_W){SIGNED & i_sample[IN_W-1]}}, i_sample};
    if (!i_valid)
      sum = acc;
    else if (SATURATE && (&acc))
      sum = acc;
    else
      sum = acc + ext;
    next_result = o_result;
    next_acc    = sum;
    if (i_interval_end)
    begin
      next_result = sum;
      next_acc    = '0;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      acc      <= '0;
      o_result <= '0;
    end
    else
    begin
      acc      <= next_acc;
      o_result <= next_result;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  latch_at_end_a: assert property (i_interval_end |=> o_result == $past(sum))
    else $error("meter result not latched at interval end");
  restart_zero_a: assert property (i_interval_end |=> acc == '0)
    else $error("meter did not restart from zero");
  saturate_hold_a: assert property (SATURATE && (&acc) && !i_interval_end |=> &acc)
    else $error("saturating meter wrapped");
endmodule // interval_meter

// ==== src/eq_meter_regs.sv ====
// Purpose: equalizer and predictor mode registers plus phase and overflow meters
// Assumes: AXI4-Lite master, meter interval strobe and samples on i_clk
// Notes:   register data sits in byte lane 0, upper bits read zero
`timescale 1ns/10ps
// Overview of operation
// - with adaptation on, the last-tap bit adapts only the oldest tap, else all taps adapt.
// - with equalizer adaptation on, the clear bit holds every equalizer tap at zero.
// - the equalizer adapt enable lets taps move when set and freezes them when clear.
// - the equalizer gain bit makes the adaptation step four times larger.
// - the predictor bypass bit forces the correction term to zero, adaptation goes on.
// - with predictor adaptation on, its clear bit holds every predictor tap at zero.
// - the predictor adapt enable lets its taps move when set and freezes them when clear.
// - the phase detector output is summed into a 26-bit signed meter per interval.
// - the phase pair shows sum bits 17:10 in the low byte and 25:18 in the high byte.
// - the phase sum is latched at every interval end, the pair's high byte is copied from it at each low byte read.
// - adc overflows are counted in an 8-bit counter that sticks at its maximum.
// - the overflow count is copied to its read-only byte at every interval end.
module eq_meter_regs
  import eq_meter_pkg::*;
#(
  parameter int PD_W   = 12,
  parameter int CORR_W = 16
) (
  input  wire logic                           i_clk,
  input  wire logic                           i_resetn,
  input  wire logic [eq_meter_pkg::ADDR_W-1:0] i_awaddr,
  input  wire logic                           i_awvalid,
  output logic                                o_awready,
  input  wire logic [eq_meter_pkg::DATA_W-1:0] i_wdata,
  input  wire logic [3:0]                     i_wstrb,
  input  wire logic                           i_wvalid,
  output logic                                o_wready,
  output logic [1:0]                          o_bresp,
  output logic                                o_bvalid,
  input  wire logic                           i_bready,
  input  wire logic [eq_meter_pkg::ADDR_W-1:0] i_araddr,
  input  wire logic                           i_arvalid,
  output logic                                o_arready,
  output logic [eq_meter_pkg::DATA_W-1:0]     o_rdata,
  output logic [1:0]                          o_rresp,
  output logic                                o_rvalid,
  input  wire logic                           i_rready,
  input  wire logic                           i_meter_interval_end,
  input  wire logic                           i_phase_valid,
  input  wire logic [PD_W-1:0]                i_phase_sample,
  input  wire logic                           i_adc_overflow,
  input  wire logic [CORR_W-1:0]              i_pred_correction,
  output logic [CORR_W-1:0]                   o_pred_correction,
  output logic                                o_eq_adapt_enable,
  output logic                                o_eq_adapt_all,
  output logic                                o_eq_adapt_last_only,
  output logic                                o_eq_coeff_zero,
  output logic [1:0]                          o_eq_step_shift,
  output logic                                o_pred_adapt_enable,
  output logic                                o_pred_coeff_zero,
  output logic                                o_pred_gain_high
);
  function automatic logic [ADDR_W-3:0] word_index(input logic [ADDR_W-1:0] addr);
    word_index = addr[ADDR_W-1:2];
  endfunction

  logic [MODE_W-1:0]      eq_mode;
  logic [MODE_W-1:0]      next_eq_mode;
  logic [MODE_W-1:0]      pred_mode;
  logic [MODE_W-1:0]      next_pred_mode;
  wr_state_t              wr_state;
  wr_state_t              next_wr_state;
  logic                   aw_held;
  logic                   next_aw_held;
  logic                   w_held;
  logic                   next_w_held;
  logic [ADDR_W-1:0]      awaddr_q;
  logic [ADDR_W-1:0]      next_awaddr_q;
  logic [REG_W-1:0]       wdata_q;
  logic [REG_W-1:0]       next_wdata_q;
  logic                   wlane_q;
  logic                   next_wlane_q;
  logic                   next_awready;
  logic                   next_wready;
  logic [1:0]             next_bresp;
  logic                   next_bvalid;
  logic [ADDR_W-3:0]      widx;
  logic                   next_arready;
  logic [DATA_W-1:0]      next_rdata;
  logic [1:0]             next_rresp;
  logic                   next_rvalid;
  logic [ADDR_W-3:0]      ridx;
  logic [REG_W-1:0]       phase_high_shadow;
  logic [REG_W-1:0]       next_phase_high_shadow;
  logic [PHASE_ACC_W-1:0] phase_result;
  logic [OVF_ACC_W-1:0]   ovf_result;

  interval_meter #(
    .ACC_W    (PHASE_ACC_W),
    .IN_W     (PD_W),
    .SIGNED   (1'b1),
    .SATURATE (1'b0)
  ) u_phase_meter (
    .i_clk          (i_clk),
    .i_resetn       (i_resetn),
    .i_interval_end (i_meter_interval_end),
    .i_valid        (i_phase_valid),
    .i_sample       (i_phase_sample),
    .o_result       (phase_result)
  );

  interval_meter #(
    .ACC_W    (OVF_ACC_W),
    .IN_W     (1),
    .SIGNED   (1'b0),
    .SATURATE (1'b1)
  ) u_overflow_meter (
    .i_clk          (i_clk),
    .i_resetn       (i_resetn),
    .i_interval_end (i_meter_interval_end),
    .i_valid        (i_adc_overflow),
    .i_sample       (1'b1),
    .o_result       (ovf_result)
  );

  // write channel: address and data may come in either order
  always_comb
  begin
    next_wr_state  = wr_state;
    next_aw_held   = aw_held;
    next_w_held    = w_held;
    next_awaddr_q  = awaddr_q;
    next_wdata_q   = wdata_q;
    next_wlane_q   = wlane_q;
    next_bresp     = o_bresp;
    next_eq_mode   = eq_mode;
    next_pred_mode = pred_mode;
    widx           = '0;
    if (o_awready && i_awvalid)
    begin
      next_aw_held  = 1'b1;
      next_awaddr_q = i_awaddr;
    end
    if (o_wready && i_wvalid)
    begin
      next_w_held  = 1'b1;
      next_wdata_q = i_wdata[REG_W-1:0];
      next_wlane_q = i_wstrb[0];
    end
    case (wr_state)
      WR_COLLECT:
      begin
        if (next_aw_held && next_w_held)
        begin
          widx          = word_index(next_awaddr_q);
          next_aw_held  = 1'b0;
          next_w_held   = 1'b0;
          next_wr_state = WR_RESP;
          next_bresp    = RESP_OKAY;
          // meters are read only, writes there are dropped quietly
          if (widx == IDX_EQ_MODE && next_wlane_q)
            next_eq_mode = next_wdata_q[MODE_W-1:0];
          else if (widx == IDX_PRED_MODE && next_wlane_q)
            next_pred_mode = next_wdata_q[MODE_W-1:0];
          else if (widx != IDX_EQ_MODE && widx != IDX_PRED_MODE && widx != IDX_PHASE_LOW
                   && widx != IDX_PHASE_HIGH && widx != IDX_OVF_COUNT)
            next_bresp = RESP_SLVERR;
        end
      end
      WR_RESP:
      begin
        if (i_bready)
          next_wr_state = WR_COLLECT;
      end
      default: next_wr_state = WR_COLLECT;
    endcase
    next_bvalid  = (next_wr_state == WR_RESP);
    next_awready = !next_aw_held && !next_bvalid;
    next_wready  = !next_w_held && !next_bvalid;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_state  <= WR_COLLECT;
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= '0;
      wlane_q   <= 1'b0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= RESP_OKAY;
      eq_mode   <= EQ_MODE_RESET;
      pred_mode <= PRED_MODE_RESET;
    end
    else
    begin
      wr_state  <= next_wr_state;
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      awaddr_q  <= next_awaddr_q;
      wdata_q   <= next_wdata_q;
      wlane_q   <= next_wlane_q;
      o_awready <= next_awready;
      o_wready  <= next_wready;
      o_bvalid  <= next_bvalid;
      o_bresp   <= next_bresp;
      eq_mode   <= next_eq_mode;
      pred_mode <= next_pred_mode;
    end
  end

  // read channel; the low byte read freezes the high byte so the pair stays coherent
  always_comb
  begin
    next_rdata             = o_rdata;
    next_rresp             = o_rresp;
    next_rvalid            = o_rvalid;
    next_phase_high_shadow = phase_high_shadow;
    ridx                   = word_index(i_araddr);
    if (o_rvalid && i_rready)
      next_rvalid = 1'b0;
    if (o_arready && i_arvalid)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      case (ridx)
        IDX_EQ_MODE:    next_rdata[MODE_W-1:0] = eq_mode;
        IDX_PRED_MODE:  next_rdata[MODE_W-1:0] = pred_mode;
        IDX_PHASE_LOW:
        begin
          next_rdata[REG_W-1:0]  = phase_result[PHASE_LOW_LSB +: REG_W];
          next_phase_high_shadow = phase_result[PHASE_HIGH_LSB +: REG_W];
        end
        IDX_PHASE_HIGH: next_rdata[REG_W-1:0] = phase_high_shadow;
        IDX_OVF_COUNT:  next_rdata[REG_W-1:0] = ovf_result;
        default:        next_rresp = RESP_SLVERR;
      endcase
    end
    next_arready = !next_rvalid;
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_arready         <= 1'b0;
      o_rvalid          <= 1'b0;
      o_rdata           <= '0;
      o_rresp           <= RESP_OKAY;
      phase_high_shadow <= '0;
    end
    else
    begin
      o_arready         <= next_arready;
      o_rvalid          <= next_rvalid;
      o_rdata           <= next_rdata;
      o_rresp           <= next_rresp;
      phase_high_shadow <= next_phase_high_shadow;
    end
  end

  // mode controls to the datapath, one cycle behind the register
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_eq_adapt_enable    <= 1'b0;
      o_eq_adapt_all       <= 1'b0;
      o_eq_adapt_last_only <= 1'b0;
      o_eq_coeff_zero      <= 1'b0;
      o_eq_step_shift      <= EQ_STEP_SHIFT_LOW;
      o_pred_adapt_enable  <= 1'b0;
      o_pred_coeff_zero    <= 1'b0;
      o_pred_gain_high     <= 1'b0;
      o_pred_correction    <= '0;
    end
    else
    begin
      o_eq_adapt_enable    <= eq_mode[EQ_ADAPT_BIT];
      o_eq_adapt_all       <= eq_mode[EQ_ADAPT_BIT] & ~eq_mode[EQ_LAST_ONLY_BIT];
      o_eq_adapt_last_only <= eq_mode[EQ_ADAPT_BIT] & eq_mode[EQ_LAST_ONLY_BIT];
      o_eq_coeff_zero      <= eq_mode[EQ_ADAPT_BIT] & eq_mode[EQ_ZERO_BIT];
      o_eq_step_shift      <= eq_mode[EQ_GAIN_BIT] ? EQ_STEP_SHIFT_HIGH
                                                   : EQ_STEP_SHIFT_LOW;
      o_pred_adapt_enable  <= pred_mode[PRED_ADAPT_BIT];
      o_pred_coeff_zero    <= pred_mode[PRED_ADAPT_BIT] & pred_mode[PRED_ZERO_BIT];
      o_pred_gain_high     <= pred_mode[PRED_GAIN_BIT];
      // bypass only touches the correction, adaptation keeps running
      o_pred_correction    <= pred_mode[PRED_ZERO_OUT_BIT] ? '0 : i_pred_correction;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence low_read_taken;
    o_arready && i_arvalid && word_index(i_araddr) == IDX_PHASE_LOW;
  endsequence

  eq_last_only_a: assert property (o_eq_adapt_last_only |-> o_eq_adapt_enable && !o_eq_adapt_all)
    else $error("last tap mode without enable or with all taps");
  eq_clear_a: assert property (eq_mode[EQ_ADAPT_BIT] && eq_mode[EQ_ZERO_BIT] |=> o_eq_coeff_zero)
    else $error("equalizer clear not applied");
  eq_freeze_a: assert property (!o_eq_adapt_enable |-> !o_eq_adapt_all && !o_eq_coeff_zero)
    else $error("equalizer moves while frozen");
  eq_step_gain_a: assert property (o_eq_step_shift == ($past(eq_mode[EQ_GAIN_BIT]) ? 2'h2 : 2'h0))
    else $error("equalizer step shift wrong");
  pred_bypass_a: assert property (pred_mode[PRED_ZERO_OUT_BIT] |=> o_pred_correction == '0)
    else $error("predictor correction not zeroed");
  pred_clear_off_a: assert property (!pred_mode[PRED_ADAPT_BIT] |=> !o_pred_coeff_zero)
    else $error("predictor clear acts while frozen");
  pred_enable_a: assert property (##1 o_pred_adapt_enable == $past(pred_mode[PRED_ADAPT_BIT]))
    else $error("predictor enable not following register");
  phase_pair_a: assert property (low_read_taken |=> o_rdata[7:0] == $past(phase_result[17:10])
                                 && phase_high_shadow == $past(phase_result[25:18]))
    else $error("phase pair bytes wrong");
  ovf_read_a: assert property (o_arready && i_arvalid && word_index(i_araddr) == IDX_OVF_COUNT
                               |=> o_rvalid && o_rdata == {24'h0, $past(ovf_result)})
    else $error("overflow count read wrong");
endmodule // eq_meter_regs

// ==== testbench/axi_lite_host.sv ====
// Purpose: AXI4-Lite host model that reads and writes the mode and meter registers
// Assumes: every task is entered just after a rising edge of i_clk
// Notes:   released payload shows inverted data, so a stale value never passes for a fresh one
`timescale 1ns/10ps
module axi_lite_host
  import eq_meter_pkg::*;
(
  input  wire logic                            i_clk,
  output logic      [eq_meter_pkg::ADDR_W-1:0] o_awaddr,
  output logic                                 o_awvalid,
  input  wire logic                            i_awready,
  output logic      [eq_meter_pkg::DATA_W-1:0] o_wdata,
  output logic      [3:0]                      o_wstrb,
  output logic                                 o_wvalid,
  input  wire logic                            i_wready,
  input  wire logic [1:0]                      i_bresp,
  input  wire logic                            i_bvalid,
  output logic                                 o_bready,
  output logic      [eq_meter_pkg::ADDR_W-1:0] o_araddr,
  output logic                                 o_arvalid,
  input  wire logic                            i_arready,
  input  wire logic [eq_meter_pkg::DATA_W-1:0] i_rdata,
  input  wire logic [1:0]                      i_rresp,
  input  wire logic                            i_rvalid,
  output logic                                 o_rready
);
  initial
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready, o_araddr, o_arvalid, o_rready} = '0;

  task automatic write(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data,
                       input logic [3:0] strb, output logic [1:0] resp);
    bit aw_left;
    bit w_left;
    aw_left = 1'b1;
    w_left  = 1'b1;
    o_awaddr  <= addr;
    o_awvalid <= 1'b1;
    o_wdata   <= data;
    o_wstrb   <= strb;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    while (aw_left || w_left)
    begin
      @(posedge i_clk);
      if (aw_left && i_awready)
      begin
        aw_left = 1'b0;
        o_awvalid <= 1'b0;
        o_awaddr  <= ~addr;
      end
      if (w_left && i_wready)
      begin
        w_left = 1'b0;
        o_wvalid <= 1'b0;
        o_wdata  <= ~data;
      end
    end
    do @(posedge i_clk); while (i_bvalid !== 1'b1);
    o_bready <= 1'b0;
    resp = i_bresp;
  endtask

  task automatic read(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data,
                      output logic [1:0] resp);
    o_araddr  <= addr;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    do @(posedge i_clk); while (i_arready !== 1'b1);
    o_arvalid <= 1'b0;
    o_araddr  <= ~addr;
    do @(posedge i_clk); while (i_rvalid !== 1'b1);
    o_rready <= 1'b0;
    data = i_rdata;
    resp = i_rresp;
    // one idle edge, so a read that follows never raises rready in the step that lowered it
    @(posedge i_clk);
  endtask

  // low byte first, high byte right after, nothing in between: the high byte comes from a shadow
  task automatic read_phase(output logic [15:0] val);
    logic [DATA_W-1:0] d;
    logic [1:0]        r;
    read({IDX_PHASE_LOW, 2'b00}, d, r);
    val[7:0] = d[7:0];
    read({IDX_PHASE_HIGH, 2'b00}, d, r);
    val[15:8] = d[7:0];
  endtask
endmodule // axi_lite_host

// ==== testbench/tb.sv ====
// Purpose: self-checking bench for the equalizer mode and meter register bank
// Assumes: host model speaks AXI4-Lite, meter inputs are driven here on i_clk
// Notes:   random data from a fixed-seed lfsr, with full-scale meter intervals as corner cases
`timescale 1ns/10ps
module tb;
  import eq_meter_pkg::*;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [3:0]        wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [1:0]        bresp, rresp, eq_shift;
  logic              interval_end = 1'b0, phase_valid = 1'b0, adc_overflow = 1'b0;
  logic [11:0]       phase_sample = '0;
  logic [15:0]       corr_in = '0, corr_out;
  logic              eq_en, eq_all, eq_last, eq_zero, pred_en, pred_zero, pred_gain;
  logic [15:0]       lfsr = 16'ha998;
  logic [25:0]       exp_sum;
  int                exp_ovf;
  int                num_errors = 0;
  int                n_checks = 0;
  logic [9:0]        reg_idx [5] = '{IDX_EQ_MODE, IDX_PRED_MODE, IDX_PHASE_LOW,
                                     IDX_PHASE_HIGH, IDX_OVF_COUNT};

  always #2.5 clk = ~clk;

  eq_meter_regs uut (.i_clk(clk), .i_resetn(resetn), .i_awaddr(awaddr), .i_awvalid(awvalid),
    .o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready), .i_meter_interval_end(interval_end),
    .i_phase_valid(phase_valid), .i_phase_sample(phase_sample), .i_adc_overflow(adc_overflow),
    .i_pred_correction(corr_in), .o_pred_correction(corr_out), .o_eq_adapt_enable(eq_en),
    .o_eq_adapt_all(eq_all), .o_eq_adapt_last_only(eq_last), .o_eq_coeff_zero(eq_zero),
    .o_eq_step_shift(eq_shift), .o_pred_adapt_enable(pred_en), .o_pred_coeff_zero(pred_zero),
    .o_pred_gain_high(pred_gain));

  axi_lite_host host (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
    .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr), .o_arvalid(arvalid),
    .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp), .i_rvalid(rvalid),
    .o_rready(rready));

  function automatic logic [15:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr;
  endfunction

  // last-tap and clear only count while adaptation is on
  function automatic logic [5:0] eq_exp(input logic [3:0] m);
    return {m[1], m[1] & ~m[3], m[1] & m[3], m[1] & m[2],
            m[0] ? EQ_STEP_SHIFT_HIGH : EQ_STEP_SHIFT_LOW};
  endfunction

  task automatic check_data(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic results();
    if (num_errors == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic reset_check();
    logic [31:0] d;
    logic [1:0]  r;
    for (int j = 0; j < 5; j++)
    begin
      host.read({reg_idx[j], 2'b00}, d, r);
      check_data("reset value", 32'h0, d);
    end
    check_data("reset outputs", 32'h0, 32'({eq_en, eq_all, eq_last, eq_zero, eq_shift,
                                            pred_en, pred_zero, pred_gain}));
  endtask

  // kind 0 random, 1 full-scale positive, 2 full-scale negative; last cycle ends the interval
  task automatic run_interval(input int n, input int kind);
    logic [15:0] x;
    logic [11:0] smp;
    logic        v;
    logic        o;
    exp_sum = '0;
    exp_ovf = 0;
    for (int c = 0; c < n; c++)
    begin
      x = rnd();
      smp = (kind == 0) ? x[11:0] : ((kind == 1) ? 12'h7ff : 12'h800);
      v = (kind == 0) ? x[12] : 1'b1;
      o = (kind == 0) ? x[13] : 1'b1;
      phase_valid  <= v;
      phase_sample <= smp;
      adc_overflow <= o;
      interval_end <= (c == n - 1);
      if (v)
        exp_sum = exp_sum + {{14{smp[11]}}, smp};
      if (o && exp_ovf < 255)
        exp_ovf++;
      @(posedge clk);
    end
    {phase_valid, adc_overflow, interval_end} <= 3'b000;
    @(posedge clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  initial
  begin
    logic [31:0]       d;
    logic [1:0]        r;
    logic [15:0]       p;
    logic [7:0]        v;
    logic [ADDR_W-1:0] a;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reset_check();
    for (int i = 0; i < 32; i++)
    begin
      p = rnd();
      v = {p[7:4], 4'(i)};
      a = (i < 16) ? {IDX_EQ_MODE, 2'b00} : {IDX_PRED_MODE, 2'b00};
      corr_in <= rnd();
      host.write(a, {rnd(), p[15:8], v}, 4'h1, r);
      check_resp("mode write", RESP_OKAY, r);
      repeat (2) @(posedge clk);
      host.read(a, d, r);
      check_data("mode readback", {28'h0, v[3:0]}, d);
      if (i < 16)
        check_data("eq outputs", 32'(eq_exp(v[3:0])),
                   32'({eq_en, eq_all, eq_last, eq_zero, eq_shift}));
      else
        check_data("pred outputs", 32'({v[1], v[1] & v[2], v[0]}),
                   32'({pred_en, pred_zero, pred_gain}));
      if (i >= 16)
        check_data("correction", 32'(v[3] ? 16'h0 : corr_in), 32'(corr_out));
    end
    host.write({10'h03f, 2'b00}, 32'hff, 4'h1, r);
    check_resp("unmapped write", RESP_SLVERR, r);
    host.read({10'h03f, 2'b00}, d, r);
    check_resp("unmapped read", RESP_SLVERR, r);
    check_data("unmapped data", 32'h0, d);
    host.write({IDX_PRED_MODE, 2'b00}, 32'h0, 4'h0, r);
    check_resp("no strobe write", RESP_OKAY, r);
    host.read({IDX_PRED_MODE, 2'b00}, d, r);
    check_data("no strobe keeps", 32'hf, d);
    for (int k = 0; k < 4; k++)
    begin
      run_interval((k == 2) ? 300 : 200, k % 3);
      host.read_phase(p);
      check_data("phase meter", 32'(exp_sum[25:10]), 32'(p));
      host.read({IDX_OVF_COUNT, 2'b00}, d, r);
      check_data("overflow meter", 32'(exp_ovf), d);
    end
    // read-only byte must shrug off a write and still answer OKAY
    host.write({IDX_OVF_COUNT, 2'b00}, 32'h5a, 4'h1, r);
    check_resp("meter write", RESP_OKAY, r);
    host.read({IDX_OVF_COUNT, 2'b00}, d, r);
    check_data("meter after write", 32'(exp_ovf), d);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reset_check();
    results();
  end
endmodule // tb
